//--- design/status_pkg.sv
// Constants and types shared by the status reporting hierarchy.
// Assumes a single system clock and a command decoder in front.
package status_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned GROUP_W = 16;

    // ------------------------------------------------------------
    // Status byte bit positions
    // ------------------------------------------------------------
    localparam int unsigned STB_ERRQ = 2;
    localparam int unsigned STB_QUES = 3;
    localparam int unsigned STB_MAV  = 4;
    localparam int unsigned STB_ESB  = 5;
    localparam int unsigned STB_MSS  = 6;
    localparam int unsigned STB_OPER = 7;

    // ------------------------------------------------------------
    // Standard event bit positions
    // ------------------------------------------------------------
    localparam int unsigned SEV_OPC = 0;
    localparam int unsigned SEV_RQC = 1;
    localparam int unsigned SEV_QYE = 2;
    localparam int unsigned SEV_DDE = 3;
    localparam int unsigned SEV_EXE = 4;
    localparam int unsigned SEV_CME = 5;
    localparam int unsigned SEV_URQ = 6;
    localparam int unsigned SEV_PON = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_GROUP = 16'h0000;
    localparam logic [7:0]  RST_SEV   = 8'h80;

    // ------------------------------------------------------------
    // Host command codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE     = 4'h0,
        CMD_CLS      = 4'h1,
        CMD_STB_RD   = 4'h2,
        CMD_SRE_WR   = 4'h3,
        CMD_SRE_RD   = 4'h4,
        CMD_ESR_RD   = 4'h5,
        CMD_ESE_WR   = 4'h6,
        CMD_ESE_RD   = 4'h7,
        CMD_OPC      = 4'h8,
        CMD_GRP_COND = 4'h9,
        CMD_GRP_EVT  = 4'hA,
        CMD_GRP_NTR  = 4'hB,
        CMD_GRP_PTR  = 4'hC,
        CMD_GRP_ENA  = 4'hD,
        CMD_GRP_RD   = 4'hE
    } cmd_t;

    // Group field select for CMD_GRP_RD
    localparam logic [1:0] FLD_COND = 2'h0;
    localparam logic [1:0] FLD_EVT  = 2'h1;
    localparam logic [1:0] FLD_NTR  = 2'h2;
    localparam logic [1:0] FLD_PTR  = 2'h3;

    typedef enum logic [2:0] {
        OPC_IDLE = 3'b001,
        OPC_WAIT = 3'b010,
        OPC_DONE = 3'b100
    } opc_state_t;
endpackage : status_pkg

//--- design/group_if.sv
// Access carrier between the top and one generic status group.
// Assumes one request per cycle, driven by the top.
`timescale 1ns/100ps
interface group_if #(parameter int unsigned W = 16);
    logic         wr_ntr;
    logic         wr_ptr;
    logic         wr_ena;
    logic         rd_evt;
    logic         clr;
    logic [W-1:0] wdata;
    logic [W-1:0] cond;
    logic [W-1:0] evt;
    logic [W-1:0] ntr;
    logic [W-1:0] ptr;
    logic [W-1:0] ena;
    logic         summary;

    modport ctrl  (output wr_ntr, wr_ptr, wr_ena, rd_evt, clr, wdata,
                   input cond, evt, ntr, ptr, ena, summary);
    modport group (input wr_ntr, wr_ptr, wr_ena, rd_evt, clr, wdata,
                   output cond, evt, ntr, ptr, ena, summary);
endinterface : group_if

//--- design/status_group.sv
// One generic status group: condition, transition filters, event, enable.
// Assumes condition inputs synchronous to clock.
`timescale 1ns/100ps
module status_group
    import status_pkg::*;
#(
    parameter int unsigned W = GROUP_W
) (
    input  wire logic   clock,
    input  wire logic   reset_n,
    input  wire logic   enable,
    input  wire logic [W-1:0] cond_in,
    group_if.group      bus
);
    // Width check at elaboration
    if (W < 1 || W > GROUP_W) begin : g_bad_width
        $error("status_group width out of range");
    end

    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] evt;
        logic [W-1:0] ntr;
        logic [W-1:0] ptr;
        logic [W-1:0] ena;
        logic         summary;
    } grp_state_t;

    grp_state_t st;
    grp_state_t next_st;
    logic [W-1:0] hits;

    always_comb begin
        next_st = st;
        next_st.prev = cond_in;
        hits = (st.prev & ~cond_in & st.ntr)
             | (~st.prev & cond_in & st.ptr);
        if (bus.rd_evt || bus.clr) begin
            next_st.evt = hits;
        end else begin
            next_st.evt = st.evt | hits;
        end
        if (bus.wr_ntr) begin
            next_st.ntr = bus.wdata;
        end
        if (bus.wr_ptr) begin
            next_st.ptr = bus.wdata;
        end
        if (bus.wr_ena) begin
            next_st.ena = bus.wdata;
        end
        next_st.summary = |(next_st.evt & next_st.ena);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (enable) begin
            st <= next_st;
        end
    end

    assign bus.cond    = cond_in;
    assign bus.evt     = st.evt;
    assign bus.ntr     = st.ntr;
    assign bus.ptr     = st.ptr;
    assign bus.ena     = st.ena;
    assign bus.summary = st.summary;
endmodule : status_group

//--- design/status_reporting_hierarchy.sv
// Status reporting hierarchy: status byte, service request enable,
// standard event group and two generic status groups.
// Assumes a command decoder presents one command per cycle, synchronous.
`timescale 1ns/100ps
module status_reporting_hierarchy
    import status_pkg::*;
#(
    parameter int unsigned OPER_W = GROUP_W,
    parameter int unsigned QUES_W = GROUP_W
) (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                enable,
    input  wire logic [3:0]          cmd,
    input  wire logic                cmd_grp,
    input  wire logic [1:0]          cmd_field,
    input  wire logic [GROUP_W-1:0]  cmd_data,
    input  wire logic                pending_busy,
    input  wire logic                err_valid,
    input  wire logic signed [15:0]  err_code,
    input  wire logic                local_key,
    input  wire logic                err_queue_nonempty,
    input  wire logic                out_queue_nonempty,
    input  wire logic [OPER_W-1:0]   oper_cond,
    input  wire logic [QUES_W-1:0]   ques_cond,
    output logic                     resp_valid,
    output logic [GROUP_W-1:0]       resp_data,
    output logic [BYTE_W-1:0]        status_byte,
    output logic                     service_request
);
    // Group width checks at elaboration
    if (OPER_W < 1 || OPER_W > GROUP_W) begin : g_bad_oper_w
        $error("OPER_W out of range");
    end
    if (QUES_W < 1 || QUES_W > GROUP_W) begin : g_bad_ques_w
        $error("QUES_W out of range");
    end

    // ------------------------------------------------------------
    // Error code ranges
    // ------------------------------------------------------------
    localparam logic signed [15:0] QYE_LO = -16'sd499;
    localparam logic signed [15:0] QYE_HI = -16'sd400;
    localparam logic signed [15:0] DDE_LO = -16'sd399;
    localparam logic signed [15:0] DDE_HI = -16'sd300;
    localparam logic signed [15:0] DEV_LO = 16'sd1;
    localparam logic signed [15:0] DEV_HI = 16'sd32767;
    localparam logic signed [15:0] EXE_LO = -16'sd299;
    localparam logic signed [15:0] EXE_HI = -16'sd200;
    localparam logic signed [15:0] CME_LO = -16'sd199;
    localparam logic signed [15:0] CME_HI = -16'sd100;

    // ------------------------------------------------------------
    // Generic groups
    // ------------------------------------------------------------
    group_if #(.W(OPER_W)) oper_bus ();
    group_if #(.W(QUES_W)) ques_bus ();

    status_group #(.W(OPER_W)) u_oper (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (enable),
        .cond_in (oper_cond),
        .bus     (oper_bus.group)
    );

    status_group #(.W(QUES_W)) u_ques (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (enable),
        .cond_in (ques_cond),
        .bus     (ques_bus.group)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [BYTE_W-1:0]  sre;
        logic [BYTE_W-1:0]  sev;
        logic [BYTE_W-1:0]  ese;
        opc_state_t         opc;
        logic               resp_valid;
        logic [GROUP_W-1:0] resp_data;
        logic [BYTE_W-1:0]  stb;
        logic               srq;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;
    cmd_t       op;
    logic [BYTE_W-1:0]  sev_hits;
    logic [BYTE_W-1:0]  stb_raw;
    logic               sev_sum;
    logic               is_cls;
    logic               g_rd;

    assign op = cmd_t'(cmd);
    assign is_cls = (op == CMD_CLS);

    // ------------------------------------------------------------
    // Group access strobes
    // ------------------------------------------------------------
    always_comb begin
        g_rd = (op == CMD_GRP_RD) && (cmd_field == FLD_EVT);
        oper_bus.wr_ntr = !cmd_grp && (op == CMD_GRP_NTR);
        oper_bus.wr_ptr = !cmd_grp && (op == CMD_GRP_PTR);
        oper_bus.wr_ena = !cmd_grp && (op == CMD_GRP_ENA);
        oper_bus.rd_evt = !cmd_grp && (g_rd || op == CMD_GRP_EVT);
        oper_bus.clr    = is_cls;
        oper_bus.wdata  = cmd_data[OPER_W-1:0];
        ques_bus.wr_ntr = cmd_grp && (op == CMD_GRP_NTR);
        ques_bus.wr_ptr = cmd_grp && (op == CMD_GRP_PTR);
        ques_bus.wr_ena = cmd_grp && (op == CMD_GRP_ENA);
        ques_bus.rd_evt = cmd_grp && (g_rd || op == CMD_GRP_EVT);
        ques_bus.clr    = is_cls;
        ques_bus.wdata  = cmd_data[QUES_W-1:0];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.resp_valid = 1'b0;
        sev_hits = '0;

        // Operation complete tracking
        case (st.opc)
            OPC_IDLE: begin
                if (op == CMD_OPC) begin
                    next_st.opc = OPC_WAIT;
                end
            end
            OPC_WAIT: begin
                if (!pending_busy) begin
                    next_st.opc = OPC_DONE;
                end
            end
            OPC_DONE: begin
                next_st.opc = OPC_IDLE;
            end
            default: begin
                next_st.opc = OPC_IDLE;
            end
        endcase
        sev_hits[SEV_OPC] = (st.opc == OPC_DONE);

        if (err_valid) begin
            sev_hits[SEV_QYE] = err_code >= QYE_LO && err_code <= QYE_HI;
            sev_hits[SEV_DDE] = (err_code >= DDE_LO && err_code <= DDE_HI)
                             || (err_code >= DEV_LO && err_code <= DEV_HI);
            sev_hits[SEV_EXE] = err_code >= EXE_LO && err_code <= EXE_HI;
            sev_hits[SEV_CME] = err_code >= CME_LO && err_code <= CME_HI;
        end
        sev_hits[SEV_URQ] = local_key;

        // Events set directly, read or clear wins only without a new hit
        if (op == CMD_ESR_RD || is_cls) begin
            next_st.sev = sev_hits;
        end else begin
            next_st.sev = st.sev | sev_hits;
        end
        next_st.sev[SEV_RQC] = 1'b0;
        if (is_cls) begin
            next_st.opc = OPC_IDLE;
        end

        if (op == CMD_SRE_WR) begin
            next_st.sre = cmd_data[BYTE_W-1:0];
        end
        if (op == CMD_ESE_WR) begin
            next_st.ese = cmd_data[BYTE_W-1:0];
        end

        // Responses
        case (op)
            CMD_STB_RD: begin
                next_st.resp_valid = 1'b1;
                next_st.resp_data  = {8'h00, st.stb};
            end
            CMD_SRE_RD: begin
                next_st.resp_valid = 1'b1;
                next_st.resp_data  = {8'h00, st.sre};
            end
            CMD_ESR_RD: begin
                next_st.resp_valid = 1'b1;
                next_st.resp_data  = {8'h00, st.sev};
            end
            CMD_ESE_RD: begin
                next_st.resp_valid = 1'b1;
                next_st.resp_data  = {8'h00, st.ese};
            end
            CMD_GRP_EVT, CMD_GRP_RD: begin
                next_st.resp_valid = 1'b1;
                if (op == CMD_GRP_EVT) begin
                    next_st.resp_data = cmd_grp ? GROUP_W'(ques_bus.evt)
                                                : GROUP_W'(oper_bus.evt);
                end else if (cmd_field == FLD_COND) begin
                    next_st.resp_data = cmd_grp ? GROUP_W'(ques_bus.cond)
                                                : GROUP_W'(oper_bus.cond);
                end else if (cmd_field == FLD_EVT) begin
                    next_st.resp_data = cmd_grp ? GROUP_W'(ques_bus.evt)
                                                : GROUP_W'(oper_bus.evt);
                end else if (cmd_field == FLD_NTR) begin
                    next_st.resp_data = cmd_grp ? GROUP_W'(ques_bus.ntr)
                                                : GROUP_W'(oper_bus.ntr);
                end else begin
                    next_st.resp_data = cmd_grp ? GROUP_W'(ques_bus.ptr)
                                                : GROUP_W'(oper_bus.ptr);
                end
            end
            CMD_GRP_COND: begin
                next_st.resp_valid = 1'b1;
                next_st.resp_data  = cmd_grp ? GROUP_W'(ques_bus.cond)
                                             : GROUP_W'(oper_bus.cond);
            end
            default: begin
                next_st.resp_data = st.resp_data;
            end
        endcase

        // Status byte from registered summaries and the unregistered queue inputs
        sev_sum = |(st.sev & st.ese);
        stb_raw = '0;
        stb_raw[STB_ERRQ] = err_queue_nonempty;
        stb_raw[STB_QUES] = ques_bus.summary;
        stb_raw[STB_MAV]  = out_queue_nonempty;
        stb_raw[STB_ESB]  = sev_sum;
        stb_raw[STB_OPER] = oper_bus.summary;
        stb_raw[STB_MSS]  = |(stb_raw & st.sre);
        next_st.stb = stb_raw;
        next_st.srq = stb_raw[STB_MSS];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st.sre        <= RST_BYTE;
            st.sev        <= RST_SEV;
            st.ese        <= RST_BYTE;
            st.opc        <= OPC_IDLE;
            st.resp_valid <= 1'b0;
            st.resp_data  <= RST_GROUP;
            st.stb        <= RST_BYTE;
            st.srq        <= 1'b0;
        end else if (enable) begin
            st <= next_st;
        end
    end

    assign resp_valid      = st.resp_valid;
    assign resp_data       = st.resp_data;
    assign status_byte     = st.stb;
    assign service_request = st.srq;
endmodule : status_reporting_hierarchy

//--- sim/status_checker.sv
// Checker on the top ports of the status reporting hierarchy.
// Assumes binding to status_reporting_hierarchy, one clock.
`timescale 1ns/100ps
module status_checker
    import status_pkg::*;
#(
    parameter int unsigned OPER_W = GROUP_W,
    parameter int unsigned QUES_W = GROUP_W
) (
    input wire logic                clock,
    input wire logic                reset_n,
    input wire logic                enable,
    input wire logic [3:0]          cmd,
    input wire logic                cmd_grp,
    input wire logic [1:0]          cmd_field,
    input wire logic [GROUP_W-1:0]  cmd_data,
    input wire logic                pending_busy,
    input wire logic                err_valid,
    input wire logic signed [15:0]  err_code,
    input wire logic                local_key,
    input wire logic                err_queue_nonempty,
    input wire logic                out_queue_nonempty,
    input wire logic [OPER_W-1:0]   oper_cond,
    input wire logic [QUES_W-1:0]   ques_cond,
    input wire logic                resp_valid,
    input wire logic [GROUP_W-1:0]  resp_data,
    input wire logic [BYTE_W-1:0]   status_byte,
    input wire logic                service_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_stb_answer;
        enable && cmd == CMD_STB_RD |=> resp_valid;
    endproperty
    property p_byte_zero;
        status_byte[1:0] == 2'h0;
    endproperty
    property p_queue_bits;
        enable |=> status_byte[STB_MAV] == $past(out_queue_nonempty)
            && status_byte[STB_ERRQ] == $past(err_queue_nonempty);
    endproperty
    property p_mss;
        service_request == status_byte[STB_MSS];
    endproperty
    property p_mss_source;
        status_byte[STB_MSS] |-> (status_byte & 8'hBF) != 8'h00;
    endproperty
    property p_resp_hold;
        !resp_valid |-> $stable(resp_data);
    endproperty
    property p_local_key;
        enable && local_key ##1 enable && cmd != CMD_ESR_RD && cmd != CMD_CLS
            ##1 enable && cmd == CMD_ESR_RD |=> resp_data[SEV_URQ];
    endproperty
    property p_cmd_err;
        enable && err_valid && err_code <= -16'sd100 && err_code >= -16'sd199
            ##1 enable && cmd != CMD_ESR_RD && cmd != CMD_CLS
            ##1 enable && cmd == CMD_ESR_RD |=> resp_data[SEV_CME];
    endproperty
    property p_rqc_zero;
        enable && cmd == CMD_ESR_RD |=> !resp_data[SEV_RQC];
    endproperty
    a_stb_answer: assert property (p_stb_answer) else $error("no status answer");
    a_byte_zero: assert property (p_byte_zero) else $error("low bits set");
    a_queue_bits: assert property (p_queue_bits) else $error("queue bits wrong");
    a_mss: assert property (p_mss) else $error("service request mismatch");
    a_mss_source: assert property (p_mss_source) else $error("summary without source");
    a_resp_hold: assert property (p_resp_hold) else $error("answer changed");
    a_local_key: assert property (p_local_key) else $error("local key lost");
    a_cmd_err: assert property (p_cmd_err) else $error("command error lost");
    a_rqc_zero: assert property (p_rqc_zero) else $error("bit 1 set");
    c_answer: cover property (resp_valid);
    c_service: cover property (service_request);
    c_oper: cover property (status_byte[STB_OPER]);
endmodule : status_checker

//--- sim/host_model.sv
// Host controller model issuing commands to the status block.
// Assumes commands change at the falling clock edge.
`timescale 1ns/100ps
module host_model
    import status_pkg::*;
(
    input  wire logic   clock,
    output logic [3:0]  cmd,
    output logic        cmd_grp,
    output logic [1:0]  cmd_field,
    output logic [15:0] cmd_data
);
    initial begin
        cmd = CMD_NONE;
        cmd_grp = 1'b0;
        cmd_field = 2'h0;
        cmd_data = 16'h0000;
    end
    task automatic send(input cmd_t c, input logic g, input logic [1:0] f,
                        input logic [15:0] d);
        @(negedge clock);
        cmd <= c;
        cmd_grp <= g;
        cmd_field <= f;
        cmd_data <= (c == CMD_SRE_WR && d[7:0] != 8'h00) ? (d | 16'h0040) : d;
    endtask : send
    task automatic idle();
        @(negedge clock);
        cmd <= CMD_NONE;
    endtask : idle
endmodule : host_model

//--- sim/tb_status_reporting_hierarchy.sv
// Testbench for the status reporting hierarchy.
// Assumes host_model for commands and status_checker bound below.
`timescale 1ns/100ps
module tb_status_reporting_hierarchy
    import status_pkg::*;
;
    logic               clock;
    logic               reset_n;
    logic               enable;
    logic [3:0]         cmd;
    logic               cmd_grp;
    logic [1:0]         cmd_field;
    logic [15:0]        cmd_data;
    logic               pending_busy;
    logic               err_valid;
    logic signed [15:0] err_code;
    logic               local_key;
    logic               err_queue_nonempty;
    logic               out_queue_nonempty;
    logic [15:0]        oper_cond;
    logic [15:0]        ques_cond;
    logic               resp_valid;
    logic [15:0]        resp_data;
    logic [7:0]         status_byte;
    logic               service_request;
    int                 fail_count;
    int                 n_checks;
    logic [15:0]        r;

    host_model u_host (.clock(clock), .cmd(cmd), .cmd_grp(cmd_grp),
        .cmd_field(cmd_field), .cmd_data(cmd_data));
    status_reporting_hierarchy u_dut (.clock(clock), .reset_n(reset_n),
        .enable(enable), .cmd(cmd), .cmd_grp(cmd_grp), .cmd_field(cmd_field),
        .cmd_data(cmd_data), .pending_busy(pending_busy), .err_valid(err_valid),
        .err_code(err_code), .local_key(local_key),
        .err_queue_nonempty(err_queue_nonempty),
        .out_queue_nonempty(out_queue_nonempty), .oper_cond(oper_cond),
        .ques_cond(ques_cond), .resp_valid(resp_valid), .resp_data(resp_data),
        .status_byte(status_byte), .service_request(service_request));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic q(input cmd_t c, input logic g, input logic [1:0] f);
        u_host.send(c, g, f, 16'h0000);
        u_host.idle();
        r = (resp_valid === 1'b1) ? resp_data : 16'hxxxx;
    endtask : q
    task automatic wr(input cmd_t c, input logic g, input logic [15:0] d);
        u_host.send(c, g, 2'h0, d);
        u_host.idle();
        repeat (2) @(negedge clock);
    endtask : wr
    task automatic err(input int code);
        @(negedge clock);
        err_valid = 1'b1;
        err_code = 16'(code);
        @(negedge clock);
        err_valid = 1'b0;
    endtask : err
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic t_power_on();
        q(CMD_ESR_RD, 1'b0, 2'h0);
        chk(r, 16'h0080);
        q(CMD_ESR_RD, 1'b0, 2'h0);
        chk(r, 16'h0000);
        u_host.send(cmd_t'(4'hF), 1'b0, 2'h0, 16'h0000);
        u_host.idle();
        chk({15'h0000, resp_valid}, 16'h0000);
        $display("test power_on done");
    endtask : t_power_on
    task automatic t_errors();
        int codes[12] = '{-499, -400, -399, -300, 1, 32767, -299, -200, -199, -100, 0, -1};
        int bits[12] = '{2, 2, 3, 3, 3, 3, 4, 4, 5, 5, 8, 8};
        for (int i = 0; i < 12; i++) begin
            err(codes[i]);
            q(CMD_ESR_RD, 1'b0, 2'h0);
            chk(r, (bits[i] < 8) ? (16'h0001 << bits[i]) : 16'h0000);
        end
        local_key = 1'b1;
        @(negedge clock);
        local_key = 1'b0;
        q(CMD_ESR_RD, 1'b0, 2'h0);
        chk(r, 16'h0040);
        $display("test errors done");
    endtask : t_errors
    task automatic t_opc();
        pending_busy = 1'b1;
        u_host.send(CMD_OPC, 1'b0, 2'h0, 16'h0000);
        u_host.idle();
        repeat (4) @(negedge clock);
        q(CMD_ESR_RD, 1'b0, 2'h0);
        chk(r, 16'h0000);
        pending_busy = 1'b0;
        repeat (4) @(negedge clock);
        q(CMD_ESR_RD, 1'b0, 2'h0);
        chk(r, 16'h0001);
        $display("test opc done");
    endtask : t_opc
    task automatic t_groups();
        wr(CMD_GRP_PTR, 1'b0, 16'h0008);
        wr(CMD_GRP_ENA, 1'b0, 16'h0008);
        oper_cond = 16'h0008;
        repeat (3) @(negedge clock);
        chk({8'h00, status_byte}, 16'h0080);
        q(CMD_GRP_RD, 1'b0, FLD_COND);
        chk(r, 16'h0008);
        q(CMD_GRP_RD, 1'b0, FLD_COND);
        chk(r, 16'h0008);
        oper_cond = 16'h0000;
        q(CMD_GRP_RD, 1'b0, FLD_EVT);
        chk(r, 16'h0008);
        q(CMD_GRP_RD, 1'b0, FLD_EVT);
        chk(r, 16'h0000);
        chk({8'h00, status_byte}, 16'h0000);
        q(CMD_GRP_RD, 1'b0, FLD_PTR);
        chk(r, 16'h0008);
        wr(CMD_GRP_NTR, 1'b1, 16'h0004);
        wr(CMD_GRP_ENA, 1'b1, 16'h0004);
        q(CMD_GRP_RD, 1'b1, FLD_NTR);
        chk(r, 16'h0004);
        ques_cond = 16'h0004;
        repeat (2) @(negedge clock);
        q(CMD_GRP_COND, 1'b1, 2'h0);
        chk(r, 16'h0004);
        ques_cond = 16'h0000;
        repeat (2) @(negedge clock);
        chk({8'h00, status_byte}, 16'h0008);
        q(CMD_GRP_EVT, 1'b1, 2'h0);
        chk(r, 16'h0004);
        q(CMD_GRP_EVT, 1'b1, 2'h0);
        chk(r, 16'h0000);
        $display("test groups done");
    endtask : t_groups
    task automatic t_service();
        wr(CMD_ESE_WR, 1'b0, 16'h0020);
        err(-150);
        wr(CMD_SRE_WR, 1'b0, 16'h0020);
        q(CMD_SRE_RD, 1'b0, 2'h0);
        chk(r, 16'h0060);
        q(CMD_ESE_RD, 1'b0, 2'h0);
        chk(r, 16'h0020);
        chk({8'h00, status_byte}, 16'h0060);
        chk({15'h0000, service_request}, 16'h0001);
        q(CMD_STB_RD, 1'b0, 2'h0);
        chk(r, 16'h0060);
        q(CMD_STB_RD, 1'b0, 2'h0);
        chk(r, 16'h0060);
        out_queue_nonempty = 1'b1;
        err_queue_nonempty = 1'b1;
        wr(CMD_SRE_WR, 1'b0, 16'h0000);
        chk({8'h00, status_byte}, 16'h0034);
        chk({15'h0000, service_request}, 16'h0000);
        wr(CMD_CLS, 1'b0, 16'h0000);
        chk({8'h00, status_byte}, 16'h0014);
        $display("test service done");
    endtask : t_service

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        stop_test();
    end
    initial begin
        reset_n = 1'b0;
        enable = 1'b1;
        pending_busy = 1'b0;
        err_valid = 1'b0;
        err_code = 16'sh0000;
        local_key = 1'b0;
        err_queue_nonempty = 1'b0;
        out_queue_nonempty = 1'b0;
        oper_cond = 16'h0000;
        ques_cond = 16'h0000;
        fail_count = 0;
        n_checks = 0;
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        t_power_on();
        t_errors();
        t_opc();
        t_groups();
        t_service();
        stop_test();
    end
endmodule : tb_status_reporting_hierarchy

bind status_reporting_hierarchy status_checker #(.OPER_W(OPER_W), .QUES_W(QUES_W)) u_chk (
    .clock(clock), .reset_n(reset_n), .enable(enable), .cmd(cmd), .cmd_grp(cmd_grp),
    .cmd_field(cmd_field), .cmd_data(cmd_data), .pending_busy(pending_busy),
    .err_valid(err_valid), .err_code(err_code), .local_key(local_key),
    .err_queue_nonempty(err_queue_nonempty), .out_queue_nonempty(out_queue_nonempty),
    .oper_cond(oper_cond), .ques_cond(ques_cond), .resp_valid(resp_valid),
    .resp_data(resp_data), .status_byte(status_byte), .service_request(service_request));
